// ==== logic/dgi_regs.svh ====
// register offsets, field positions, clock period and timing counts
`ifndef DGI_REGS_SVH
`define DGI_REGS_SVH
`define DGI_IDX_HEADSET      8'd13
`define DGI_IDX_MICBIAS      8'd25
`define DGI_IDX_SHORT_CTRL   8'd38
`define DGI_IDX_SHORT_STAT   8'd95
`define DGI_IDX_DMIC_CTRL    8'd107
`define DGI_IDX_GPIO_CFG     8'd120
`define DGI_IDX_IRQ_SRC      8'd121
`define DGI_IDX_IRQ_STAT     8'd122
`define DGI_IDX_IRQ_MASK     8'd123
`define DGI_IDX_DRV_PWR      8'd124
`define DGI_FLD_DMIC_LO      4
`define DGI_CLK_PERIOD_NS    20
`define DGI_PULSE_NS         1000
`define DGI_PULSE_CYC  ((`DGI_PULSE_NS + `DGI_CLK_PERIOD_NS - 1) / `DGI_CLK_PERIOD_NS)
`define DGI_TRAIN_NS         16000
`define DGI_TRAIN_CYC  (`DGI_TRAIN_NS / `DGI_CLK_PERIOD_NS)
`endif

// ==== logic/dgi_pkg.sv ====
// types shared by the microphone and pin logic
package dgi_pkg;
  typedef enum logic [1:0] {
    DGI_OSR_128 = 2'b00,
    DGI_OSR_64  = 2'b01,
    DGI_OSR_32  = 2'b10,
    DGI_OSR_OFF = 2'b11
  } dgi_osr_type;
  typedef enum logic [1:0] {
    DGI_PIN_IN  = 2'b00,
    DGI_PIN_OUT = 2'b01,
    DGI_PIN_CLK = 2'b10,
    DGI_PIN_IRQ = 2'b11
  } dgi_pin_mode_type;
  typedef struct packed {
    logic valid;
    logic left;
    logic right;
  } dgi_mic_type;
  typedef struct packed {
    logic agc_noise;
    logic short_det;
    logic button;
    logic jack;
  } dgi_irq_type;
endpackage : dgi_pkg

// ==== logic/dgi_top.sv ====
// digital microphone capture, general pins and interrupt logic
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dgi_regs.svh"
// Behaviour
// - mic clock on pin one at 128/64/32 fs
// - capture rising, falling or both edges
// - left data sampled on rising edge
// - right data sampled on falling edge
// - captured bits go to decimation path
// - mic mode blocks analog ADC inputs
// - mic mode set by two 2-bit fields
// - input pin level readable by host
// - output pin drives programmed level
// - pins may output clock or interrupt
// - interrupt sources routed alone or ORed
// - status register names interrupt cause
// - single pulse or train until read
// - short state readable, current limited
// - auto power-down holds until off-on cycle
// - headset type readable in register
module dgi_top
  import dgi_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        adc_fs_tick,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        gp_pin_one_in,
  output logic             gp_pin_one_out,
  output logic             gp_pin_one_oe,
  input  wire logic        gp_pin_two_in,
  output logic             gp_pin_two_out,
  output logic             gp_pin_two_oe,
  input  wire logic        jack_event,
  input  wire logic        button_event,
  input  wire logic        agc_noise_event,
  input  wire logic [1:0]  short_in,
  input  wire logic [1:0]  headset_type,
  output dgi_mic_type      mic_data,
  output logic             adc_analog_en,
  output logic      [1:0]  driver_on,
  output logic      [1:0]  current_limit,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] word_index(input logic [31:0] a);
    word_index = a[9:2];
  endfunction : word_index

  logic [1:0]  dmic_ctrl;
  logic [1:0]  dmic_edge;
  logic [1:0]  short_ctrl;
  logic [1:0]  drv_pwr;
  logic [1:0]  pin1_mode;
  logic [1:0]  pin2_mode;
  logic        pin1_level;
  logic        pin2_level;
  logic        pulse_train;
  logic [3:0]  irq_route1;
  logic [3:0]  irq_route2;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic [1:0]  short_flag;
  logic [1:0]  short_trip;
  logic        ap_sel;
  logic        ap_write;
  logic [7:0]  ap_idx;
  logic        dp_read;
  logic [1:0]  p1_sync;
  logic [1:0]  p2_sync;
  logic [1:0]  sh0_sync;
  logic [1:0]  sh1_sync;
  logic        mic_clk;
  logic [5:0]  mic_div;
  logic [5:0]  half_cnt;
  logic        clk_run;
  logic [1:0]  rise_dly;
  logic [1:0]  fall_dly;
  logic        mic_rise;
  logic        mic_fall;
  logic        stat_read;
  logic [3:0]  irq_new;
  logic        pulse_active;
  logic [15:0] pulse_cnt;
  logic [15:0] train_cnt;
  logic        irq_pin1;
  logic        irq_pin2;
  logic [31:0] next_hrdata;
  logic        mic_mode;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(irq_stat & irq_mask);
  assign mic_mode  = (dmic_ctrl != DGI_OSR_OFF);
  assign adc_analog_en = ~mic_mode;
  // the divider also runs when a pin only wants the clock, not the mic
  assign clk_run   = mic_mode || pin1_mode == DGI_PIN_CLK ||
                     pin2_mode == DGI_PIN_CLK;
  assign irq_new   = {agc_noise_event, short_flag != 2'b00 && short_trip != 2'b00,
                      button_event, jack_event};

  ////////////////////////////////////////////////////////////////////////
  // ahb address phase held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_sel   <= 1'b0;
      ap_write <= 1'b0;
      ap_idx   <= 8'h00;
      dp_read  <= 1'b0;
    end else if (clk_en && hready) begin
      ap_sel   <= hsel && htrans[1];
      ap_write <= hsel && htrans[1] && hwrite;
      ap_idx   <= word_index(haddr);
      dp_read  <= hsel && htrans[1] && !hwrite;
    end
  end

  // read data registered in the address phase so it stands in data phase
  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (word_index(haddr))
      `DGI_IDX_HEADSET:    next_hrdata[1:0] = headset_type;
      `DGI_IDX_MICBIAS:    next_hrdata[5:4] = dmic_edge;
      `DGI_IDX_SHORT_CTRL: next_hrdata[2:1] = short_ctrl;
      `DGI_IDX_SHORT_STAT: next_hrdata[1:0] = short_flag;
      `DGI_IDX_DMIC_CTRL:  next_hrdata[5:4] = dmic_ctrl;
      `DGI_IDX_GPIO_CFG:   next_hrdata = {15'h0000, pulse_train,
                             irq_route2, irq_route1, p2_sync[1], p1_sync[1],
                             pin2_level, pin1_level, pin2_mode, pin1_mode};
      `DGI_IDX_IRQ_SRC,
      `DGI_IDX_IRQ_STAT:   next_hrdata[3:0] = irq_stat;
      `DGI_IDX_IRQ_MASK:   next_hrdata[3:0] = irq_mask;
      `DGI_IDX_DRV_PWR:    next_hrdata[1:0] = drv_pwr;
      default:             next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  assign stat_read = clk_en && dp_read && ap_sel &&
                     (ap_idx == `DGI_IDX_IRQ_STAT);

  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dmic_ctrl   <= DGI_OSR_OFF;
      dmic_edge   <= 2'b11;
      short_ctrl  <= 2'b00;
      drv_pwr     <= 2'b00;
      pin1_mode   <= DGI_PIN_IN;
      pin2_mode   <= DGI_PIN_IN;
      pin1_level  <= 1'b0;
      pin2_level  <= 1'b0;
      irq_route1  <= 4'h0;
      irq_route2  <= 4'h0;
      pulse_train <= 1'b0;
      irq_mask    <= 4'h0;
    end else if (clk_en && ap_write) begin
      unique case (ap_idx)
        `DGI_IDX_DMIC_CTRL:  dmic_ctrl  <= hwdata[5:4];
        `DGI_IDX_MICBIAS:    dmic_edge  <= hwdata[5:4];
        `DGI_IDX_SHORT_CTRL: short_ctrl <= hwdata[2:1];
        `DGI_IDX_DRV_PWR:    drv_pwr    <= hwdata[1:0];
        `DGI_IDX_IRQ_MASK:   irq_mask   <= hwdata[3:0];
        `DGI_IDX_GPIO_CFG: begin
          pin1_mode   <= hwdata[1:0];
          pin2_mode   <= hwdata[3:2];
          pin1_level  <= hwdata[4];
          pin2_level  <= hwdata[5];
          irq_route1  <= hwdata[11:8];
          irq_route2  <= hwdata[15:12];
          pulse_train <= hwdata[16];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin and short inputs pass two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p1_sync  <= 2'b00;
      p2_sync  <= 2'b00;
      sh0_sync <= 2'b00;
      sh1_sync <= 2'b00;
    end else if (clk_en) begin
      p1_sync  <= {p1_sync[0], gp_pin_one_in};
      p2_sync  <= {p2_sync[0], gp_pin_two_in};
      sh0_sync <= {sh0_sync[0], short_in[0]};
      sh1_sync <= {sh1_sync[0], short_in[1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // short protection: limiter follows the synced short input, flag latches until driver power is off, trips power-down when auto
  assign short_trip    = {sh1_sync[1], sh0_sync[1]};
  assign current_limit = short_trip;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_flag <= 2'b00;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if (short_trip[i] && drv_pwr[i]) begin
          short_flag[i] <= 1'b1;
        end else if (!drv_pwr[i]) begin
          short_flag[i] <= 1'b0;
        end
      end
    end
  end
  // auto mode keeps the driver off until software cycles it off then on
  assign driver_on = drv_pwr & ~(short_flag & {2{short_ctrl[1]}});

  ////////////////////////////////////////////////////////////////////////
  // mic clock: restart on each fs tick, divide to the oversampling ratio
  always_comb begin
    unique case (dmic_ctrl)
      DGI_OSR_64: mic_div = 6'd2;
      DGI_OSR_32: mic_div = 6'd4;
      default:    mic_div = 6'd1;
    endcase
  end

  // fs period is 256 clocks at 50 MHz/~195k; ratio 128 uses 1-cycle halves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt <= 6'd0;
      mic_clk  <= 1'b0;
    end else if (clk_en) begin
      if (!clk_run || adc_fs_tick) begin
        half_cnt <= 6'd0;
        mic_clk  <= 1'b0;
      end else if (half_cnt + 6'd1 >= mic_div) begin
        half_cnt <= 6'd0;
        mic_clk  <= ~mic_clk;
      end else begin
        half_cnt <= half_cnt + 6'd1;
      end
    end
  end

  assign mic_rise = mic_mode && clk_en && !mic_clk && half_cnt + 6'd1 >= mic_div
                    && !adc_fs_tick;
  assign mic_fall = mic_mode && clk_en && mic_clk && half_cnt + 6'd1 >= mic_div
                    && !adc_fs_tick;

  // capture data at the edges the device drives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mic_data <= '0;
      rise_dly <= 2'b00;
      fall_dly <= 2'b00;
    end else if (clk_en) begin
      // strobes trail the edge by the two sync flops, else at 64x the
      // synced bit would already belong to the other channel's slot
      rise_dly <= {rise_dly[0], mic_rise};
      fall_dly <= {fall_dly[0], mic_fall};
      mic_data.valid <= 1'b0;
      if (rise_dly[1] && dmic_edge[0]) begin
        mic_data.left  <= p2_sync[1];
        mic_data.valid <= 1'b1;
      end
      if (fall_dly[1] && dmic_edge[1]) begin
        mic_data.right <= p2_sync[1];
        mic_data.valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky causes; a new event wins over the read that clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= 4'h0;
    end else if (clk_en) begin
      // only causes the host has seen in the read data are cleared
      irq_stat <= (irq_stat & ~(stat_read ? hrdata[3:0] : 4'h0)) |
                  irq_new;
    end
  end

  // pulse generator: one pulse per event, or repeating until read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_active <= 1'b0;
      pulse_cnt    <= 16'h0000;
      train_cnt    <= 16'h0000;
    end else if (clk_en) begin
      if (|irq_new) begin
        pulse_active <= 1'b1;
        pulse_cnt    <= 16'h0000;
        train_cnt    <= 16'h0000;
      end else if (stat_read) begin
        pulse_active <= 1'b0;
      end else if (pulse_active) begin
        pulse_cnt <= (pulse_cnt < 16'(`DGI_PULSE_CYC)) ? pulse_cnt + 16'd1
                                                      : pulse_cnt;
        if (pulse_cnt >= 16'(`DGI_PULSE_CYC) && !pulse_train) begin
          pulse_active <= 1'b0;
        end
        if (train_cnt >= 16'(`DGI_TRAIN_CYC) - 16'd1) begin
          train_cnt <= 16'h0000;
          pulse_cnt <= 16'h0000;
        end else begin
          train_cnt <= train_cnt + 16'd1;
        end
      end
    end
  end

  // each pin picks its own set of sources
  assign irq_pin1 = pulse_active && pulse_cnt < 16'(`DGI_PULSE_CYC) &&
                    |(irq_stat & irq_route1);
  assign irq_pin2 = pulse_active && pulse_cnt < 16'(`DGI_PULSE_CYC) &&
                    |(irq_stat & irq_route2);

  ////////////////////////////////////////////////////////////////////////
  // pin drivers; mic mode takes both pins over
  always_comb begin
    gp_pin_one_oe  = 1'b0;
    gp_pin_one_out = 1'b0;
    gp_pin_two_oe  = 1'b0;
    gp_pin_two_out = 1'b0;
    if (mic_mode) begin
      gp_pin_one_oe  = 1'b1;
      gp_pin_one_out = mic_clk;
    end else begin
      unique case (pin1_mode)
        DGI_PIN_OUT: begin
          gp_pin_one_oe  = 1'b1;
          gp_pin_one_out = pin1_level;
        end
        DGI_PIN_CLK: begin
          gp_pin_one_oe  = 1'b1;
          gp_pin_one_out = mic_clk;
        end
        DGI_PIN_IRQ: begin
          gp_pin_one_oe  = 1'b1;
          gp_pin_one_out = irq_pin1;
        end
        default: ;
      endcase
      unique case (pin2_mode)
        DGI_PIN_OUT: begin
          gp_pin_two_oe  = 1'b1;
          gp_pin_two_out = pin2_level;
        end
        DGI_PIN_CLK: begin
          gp_pin_two_oe  = 1'b1;
          gp_pin_two_out = mic_clk;
        end
        DGI_PIN_IRQ: begin
          gp_pin_two_oe  = 1'b1;
          gp_pin_two_out = irq_pin2;
        end
        default: ;
      endcase
    end
  end
endmodule : dgi_top
`default_nettype wire

// ==== sim/dgi_checker.sv ====
// concurrent checks on the bus, pin and microphone ports
`timescale 1ns/10ps
`default_nettype none
module dgi_checker
  import dgi_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        gp_pin_one_out,
  input wire logic        gp_pin_one_oe,
  input wire logic        gp_pin_two_oe,
  input wire logic [1:0]  short_in,
  input wire dgi_mic_type mic_data,
  input wire logic        adc_analog_en,
  input wire logic [1:0]  current_limit
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd_take;
  assign rd_take = hsel & htrans[1] & ~hwrite & hready;
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stall or error reply");
  read_hold_a: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  clk_pin_a: assert property (!adc_analog_en |-> gp_pin_one_oe)
    else $error("mic clock pin not driven");
  clk_high_a: assert property ($rose(gp_pin_one_out) && !adc_analog_en
    |-> ##[1:4] (!gp_pin_one_out || adc_analog_en))
    else $error("mic clock high too long");
  clk_low_a: assert property ($fell(gp_pin_one_out) && !adc_analog_en
    |-> ##[1:4] (gp_pin_one_out || adc_analog_en))
    else $error("mic clock low too long");
  data_pin_a: assert property (!adc_analog_en |-> !gp_pin_two_oe)
    else $error("mic data pin driven");
  // a late capture may trail the mode switch by the sync lag
  valid_mode_a: assert property (mic_data.valid
    |-> !adc_analog_en || !$past(adc_analog_en, 4))
    else $error("capture outside mic mode");
  limit_sync_a: assert property ($past(hresetn) && $past(hresetn, 2)
    |-> current_limit == $past(short_in, 2))
    else $error("current limit not following short");
endmodule : dgi_checker
`default_nettype wire

// ==== sim/dgi_mic_model.sv ====
// behavioural digital microphone on the two general pins
`timescale 1ns/10ps
`default_nettype none
module dgi_mic_model (
  input  wire logic hclk,
  input  wire logic mic_clk,
  input  wire logic mic_clk_oe,
  input  wire logic left_bit,
  input  wire logic right_bit,
  output var  logic data_out
);
  initial data_out = 1'b0;
  // bit changes just after an edge so it is stable at the next one
  always @(negedge mic_clk) if (mic_clk_oe) data_out <= #4 left_bit;
  always @(posedge mic_clk) if (mic_clk_oe) data_out <= #4 right_bit;
  // no clock: the line wanders, nothing valid to latch
  always @(posedge hclk) if (!mic_clk_oe) data_out <= ~data_out;
endmodule : dgi_mic_model
`default_nettype wire

// ==== sim/dgi_top_tb.sv ====
// self-checking bench for the mic, general pin and interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "dgi_regs.svh"
module dgi_top_tb;
  import dgi_pkg::*;
  typedef struct packed {
    logic [3:0] ev;
    logic [3:0] st;
  } dgi_row_type;
  localparam dgi_row_type rows [4] = '{'{4'h1, 4'h1}, '{4'h2, 4'h2},
                                      '{4'h8, 4'h8}, '{4'hB, 4'hB}};
  logic        hclk, hresetn, clk_en, adc_fs_tick, hsel, hwrite, hready;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans, short_in, headset_type, driver_on, current_limit;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, irq, adc_analog_en;
  logic        gp_pin_one_in, gp_pin_one_out, gp_pin_one_oe;
  logic        gp_pin_two_in, gp_pin_two_out, gp_pin_two_oe;
  logic        jack_event, button_event, agc_noise_event;
  logic        use_mic, pin_two_tb, mic_q, left_b, right_b;
  logic [7:0]  fs_cnt;
  dgi_mic_type mic_data;
  int          errors, checked, n, h, l;
  assign hready = hreadyout;
  assign gp_pin_two_in = use_mic ? mic_q : pin_two_tb;
  always #10 hclk = ~hclk;
  // 256 clocks per sample suits every ratio
  always @(posedge hclk) begin
    fs_cnt <= fs_cnt + 8'h1;
    adc_fs_tick <= &fs_cnt;
  end
  dgi_top u_dgi_top (.hclk, .hresetn, .clk_en, .adc_fs_tick, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .gp_pin_one_in, .gp_pin_one_out, .gp_pin_one_oe, .gp_pin_two_in,
    .gp_pin_two_out, .gp_pin_two_oe, .jack_event, .button_event,
    .agc_noise_event, .short_in, .headset_type, .mic_data, .adc_analog_en,
    .driver_on, .current_limit, .irq);
  dgi_mic_model u_dgi_mic_model (.hclk, .mic_clk(gp_pin_one_out),
    .mic_clk_oe(gp_pin_one_oe), .left_bit(left_b), .right_bit(right_b),
    .data_out(mic_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input int idx, input logic [31:0] wd);
    int k;
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 32'(idx * 4)};
    k = 0;
    do begin @(posedge hclk); k++; end while (!hreadyout && k < 50);
    {htrans, hwdata} <= {2'h0, wd};
    do begin @(posedge hclk); k++; end while (!hreadyout && k < 50);
    rdv = hrdata;
    if (k >= 50) begin
      errors++;
      wrap_up();
    end
  endtask : bus
  task automatic wr(input int i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask : wr
  task automatic rd(input int i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk("reg", rdv, e);
  endtask : rd
  task automatic pins(input logic [3:0] e, m);
    @(negedge hclk);
    chk("pins", {gp_pin_one_out, gp_pin_one_oe, gp_pin_two_out,
                 gp_pin_two_oe} & m, e);
  endtask : pins
  task automatic pulse(input logic [3:0] b);
    @(posedge hclk);
    {agc_noise_event, button_event, jack_event} <= {b[3], b[1], b[0]};
    @(posedge hclk);
    {agc_noise_event, button_event, jack_event} <= 3'h0;
  endtask : pulse
  // pin 1, pin 2 or the sample tick; the bound caps every wait
  task automatic until_lvl(input int s, input logic v, input int lim);
    for (n = 0; n < lim && (s == 1 ? gp_pin_one_out : s == 2 ?
         gp_pin_two_out : adc_fs_tick) !== v; n++) @(negedge hclk);
  endtask : until_lvl
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge hclk);
    errors++;
    wrap_up();
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, use_mic, pin_two_tb, gp_pin_one_in} = '0;
    {jack_event, button_event, agc_noise_event, adc_fs_tick} = '0;
    {haddr, hwdata, htrans, short_in, fs_cnt, errors, checked} = '0;
    {clk_en, left_b, right_b, hsize, headset_type} = 8'hEA;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(107, 32'h30);
    rd(25, 32'h30);
    rd(13, 32'h2);
    rd(200, 32'h0);
    gp_pin_one_in <= 1'b1;
    wr(120, 32'h0);
    rd(120, 32'h40);
    wr(120, 32'h15);
    pins(4'hD, 4'hF);
    wr(120, 32'h25);
    pins(4'h7, 4'hF);
    wr(120, 32'h0A);
    pins(4'h5, 4'h5);
    until_lvl(1, 1, 9);
    until_lvl(1, 0, 9);
    chk("clkout", n, 1);
    wr(123, 32'h0);
    pulse(4'h1);
    @(negedge hclk);
    chk("masked", irq, 0);
    wr(123, 32'hF);
    @(negedge hclk);
    chk("unmask", irq, 1);
    rd(122, 32'h1);
    foreach (rows[i]) begin
      pulse(rows[i].ev);
      @(negedge hclk);
      chk("irq", irq, 1);
      rd(122, rows[i].st);
      @(negedge hclk);
      chk("irq", irq, 0);
    end
    wr(120, 32'h100C);
    pulse(4'h2);
    until_lvl(2, 1, 60);
    chk("alone", n, 60);
    rd(122, 32'h2);
    pulse(4'h1);
    until_lvl(2, 1, 9);
    until_lvl(2, 0, 99);
    chk("pulse", n, `DGI_PULSE_CYC);
    until_lvl(2, 1, `DGI_TRAIN_CYC);
    chk("single", n, `DGI_TRAIN_CYC);
    rd(122, 32'h1);
    wr(120, 32'h1100C);
    pulse(4'h1);
    until_lvl(2, 1, 9);
    until_lvl(2, 0, 99);
    until_lvl(2, 1, `DGI_TRAIN_CYC);
    chk("train", n + `DGI_PULSE_CYC, `DGI_TRAIN_CYC);
    rd(122, 32'h1);
    until_lvl(2, 0, 99);
    until_lvl(2, 1, `DGI_TRAIN_CYC);
    chk("stop", n, `DGI_TRAIN_CYC);
    wr(120, 32'hF00C);
    pulse(4'h2);
    until_lvl(2, 1, 9);
    chk("or", n < 9, 1);
    rd(122, 32'h2);
    wr(120, 32'h0);
    wr(124, 32'h3);
    short_in <= 2'h1;
    repeat (4) @(posedge hclk);
    chk("limit", current_limit, 2'h1);
    rd(95, 32'h1);
    rd(122, 32'h4);
    short_in <= 2'h0;
    wr(124, 32'h0);
    rd(95, 32'h0);
    wr(38, 32'h4);
    wr(124, 32'h3);
    short_in <= 2'h2;
    repeat (5) @(posedge hclk);
    chk("drv", driver_on, 2'h1);
    short_in <= 2'h0;
    repeat (5) @(posedge hclk);
    chk("drv", driver_on, 2'h1);
    wr(124, 32'h1);
    wr(124, 32'h3);
    @(negedge hclk);
    chk("drv", driver_on, 2'h3);
    rd(122, 32'h4);
    use_mic <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr(107, 32'(c) << 4);
      until_lvl(3, 1, 300);
      until_lvl(1, 0, 9);
      until_lvl(1, 1, 9);
      until_lvl(1, 0, 9);
      h = n;
      until_lvl(1, 1, 9);
      chk("osr", h + n, 2 << c);
      chk("ana", adc_analog_en, 0);
    end
    for (int e = 1; e < 4; e++) begin
      wr(25, 32'(e) << 4);
      {left_b, right_b} <= {e != 2, e == 2};
      until_lvl(3, 1, 300);
      repeat (24) @(posedge hclk);
      until_lvl(1, 0, 9);
      until_lvl(1, 1, 9);
      h = 0;
      l = 0;
      repeat (32) begin
        @(negedge hclk);
        h += mic_data.valid;
        l += mic_data.valid && ((e[0] && mic_data.left !== left_b) ||
             (e[1] && mic_data.right !== right_b));
      end
      chk("edges", h, e == 3 ? 8 : 4);
      chk("bits", l, 0);
    end
    wr(107, 32'h30);
    @(negedge hclk);
    chk("ana", adc_analog_en, 1);
    wrap_up();
  end
endmodule : dgi_top_tb
bind dgi_top dgi_checker u_dgi_checker (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .gp_pin_one_out,
  .gp_pin_one_oe, .gp_pin_two_oe, .short_in, .mic_data, .adc_analog_en,
  .current_limit);
`default_nettype wire
